// ===== rtl/programmable_divider_chain.v
// Divider chain top: byte registers, checks, low-speed stage
// Function
// - Feedback setting is 11.32 unsigned fixed point
// - High-speed ratio is plain 11-bit integer
// - Odd ratios 5 to 33 keep 50% duty
// - Low-speed divides by powers of two, 1-32
// - Low-speed ratio is two to the code for codes 0 to 5
// - Codes 6 and 7 divide by 32
// - Output is VCO over both ratios
// - VCO equals reference times feedback value
// - All divider settings are unsigned
// - Packed byte holds exponent and ratio top
`timescale 1ns/100ps
`include "divider_chain_defines.vh"
module programmable_divider_chain (
   input  wire       clk_sys_in,
   input  wire       rst_n_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   output reg  [7:0] reg_rdata_out,
   output reg        reg_rvalid_out,
   output reg  [1:0] clk_out_pair_out,
   output wire       fb_ref_pulse_out,
   output reg        cfg_error_out
);
   // Staged settings as written by the host
   reg  [10:0] hs_stage_ff;
   reg  [2:0]  ls_stage_ff;
   reg  [42:0] fb_stage_ff;
   // Settings the divider chain actually runs from
   reg  [10:0] hs_active_ff;
   reg  [2:0]  ls_active_ff;
   reg  [42:0] fb_active_ff;
   // Sticky status
   reg         refused_ff;
   reg         applied_ff;
   // Low-speed stage
   reg  [2:0]  ls_run_ff;
   reg  [4:0]  ls_cnt_ff;
   // Next values
   reg  [4:0]  nxt_ls_cnt;
   reg  [2:0]  nxt_ls_run;
   reg  [1:0]  nxt_out_pair;
   reg  [7:0]  nxt_rdata;

   // High-speed stage taps
   wire [1:0]  hs_pair;
   wire        hs_start;
   // Legality of the staged set
   wire        hs_range_ok;
   wire        hs_parity_ok;
   wire        hs_ok;
   wire        fb_ok;
   wire        cfg_ok;
   // Bus decode
   wire        wr_hit_ctrl;
   wire        apply_req;
   wire        apply_ok;
   wire        apply_bad;
   wire        clr_req;
   // Low-speed decode
   wire        ls_sat;
   wire [2:0]  ls_exp_eff;
   wire [4:0]  ls_last;
   wire [4:0]  ls_half;

   // Legality checks on the staged values

   // Unsigned compares only; no setting has a sign bit
   assign hs_range_ok  = (hs_stage_ff >= `HS_MIN) &&
                         (hs_stage_ff <= `HS_MAX);
   // The duty corrector only covers odd ratios in the low range
   assign hs_parity_ok = (hs_stage_ff <= `HS_ODD_MAX) || !hs_stage_ff[0];
   assign hs_ok        = hs_range_ok && hs_parity_ok;
   assign fb_ok = (fb_stage_ff >= `FB_MIN) &&
                  (fb_stage_ff <= `FB_MAX);
   assign cfg_ok = hs_ok && fb_ok;

   // Control byte decode
   assign wr_hit_ctrl = reg_wr_in && (reg_addr_in == `REG_CTRL);
   assign apply_req   = wr_hit_ctrl && reg_wdata_in[`CTRL_APPLY_BIT];
   assign clr_req     = reg_wr_in && (reg_addr_in == `REG_STATUS);
   // An apply either lands whole or is refused whole
   assign apply_ok    = apply_req && cfg_ok;
   assign apply_bad   = apply_req && !cfg_ok;

   // Register writes into the staging bytes

   // Staged bytes reach the dividers only when an apply is written
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         hs_stage_ff <= `HS_RESET;
         ls_stage_ff <= `LS_RESET;
         fb_stage_ff <= `FB_RESET;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `REG_HS_LOW: begin
               hs_stage_ff[7:0] <= reg_wdata_in;
            end
            `REG_PACKED: begin
               ls_stage_ff       <= reg_wdata_in[`PACK_LS_MSB:`PACK_LS_LSB];
               hs_stage_ff[10:8] <= reg_wdata_in[`PACK_HS_MSB:`PACK_HS_LSB];
            end
            `REG_FB_B0: begin
               fb_stage_ff[7:0] <= reg_wdata_in;
            end
            `REG_FB_B1: begin
               fb_stage_ff[15:8] <= reg_wdata_in;
            end
            `REG_FB_B2: begin
               fb_stage_ff[23:16] <= reg_wdata_in;
            end
            `REG_FB_B3: begin
               fb_stage_ff[31:24] <= reg_wdata_in;
            end
            `REG_FB_B4: begin
               fb_stage_ff[39:32] <= reg_wdata_in;
            end
            `REG_FB_B5: begin
               fb_stage_ff[42:40] <= reg_wdata_in[2:0]; // Upper bits dropped
            end
            default: begin
               fb_stage_ff <= fb_stage_ff;
            end
         endcase
      end
   end

   // Apply: copy staged settings into the running chain

   // An illegal set is refused whole, so the chain never sees a ratio
   // that would stall the counters; the old frequency keeps running
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         hs_active_ff <= `HS_RESET;
         ls_active_ff <= `LS_RESET;
         fb_active_ff <= `FB_RESET;
      end else if (apply_ok) begin
         hs_active_ff <= hs_stage_ff;
         ls_active_ff <= ls_stage_ff;
         fb_active_ff <= fb_stage_ff;
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         refused_ff <= 1'b0;
         applied_ff <= 1'b0;
      end else begin
         // Refusal: the staged set failed a limit check
         if (apply_bad) begin
            refused_ff <= 1'b1;
         end else if (clr_req && reg_wdata_in[`ST_REFUSED]) begin
            refused_ff <= 1'b0;
         end
         // Acceptance: the running chain took the staged set
         if (apply_ok) begin
            applied_ff <= 1'b1;
         end else if (clr_req && reg_wdata_in[`ST_APPLIED]) begin
            applied_ff <= 1'b0;
         end
      end
   end

   // Error pin follows the staged check and refusals
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cfg_error_out <= 1'b0;
      end else begin
         cfg_error_out <= !cfg_ok || refused_ff;
      end
   end

   // Register reads

   // Read data is registered; unmapped bytes and unused bits read zero
   always @* begin
      nxt_rdata = 8'h00;
      case (reg_addr_in)
         `REG_HS_LOW: begin
            nxt_rdata = hs_stage_ff[7:0];
         end
         `REG_PACKED: begin
            nxt_rdata = {1'b0, ls_stage_ff, 1'b0, hs_stage_ff[10:8]};
         end
         `REG_FB_B0: begin
            nxt_rdata = fb_stage_ff[7:0];
         end
         `REG_FB_B1: begin
            nxt_rdata = fb_stage_ff[15:8];
         end
         `REG_FB_B2: begin
            nxt_rdata = fb_stage_ff[23:16];
         end
         `REG_FB_B3: begin
            nxt_rdata = fb_stage_ff[31:24];
         end
         `REG_FB_B4: begin
            nxt_rdata = fb_stage_ff[39:32];
         end
         `REG_FB_B5: begin
            nxt_rdata = {5'h00, fb_stage_ff[42:40]};
         end
         `REG_STATUS: begin
            nxt_rdata[`ST_HS_BAD]  = !hs_ok;
            nxt_rdata[`ST_FB_BAD]  = !fb_ok;
            nxt_rdata[`ST_REFUSED] = refused_ff;
            nxt_rdata[`ST_LS_SAT]  = ls_sat;
            nxt_rdata[`ST_APPLIED] = applied_ff;
         end
         default: begin
            nxt_rdata = 8'h00; // Control byte is write-only
         end
      endcase
   end

   // One-cycle read answer
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         reg_rdata_out  <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
         end
      end
   end

   // Feedback and high-speed dividers

   // System clock stands in for the VCO; the feedback pulse is what a
   // phase detector would compare against the crystal reference
   fb_divider u_fb (
      .clk_sys_in    (clk_sys_in),
      .rst_n_in      (rst_n_in),
      .value_in      (fb_active_ff),
      .ref_pulse_out (fb_ref_pulse_out)
   );

   // High-speed stage, period of hs_active_ff clocks
   hs_divider u_hs (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .ratio_in         (hs_active_ff),
      .level_pair_out   (hs_pair),
      .period_start_out (hs_start)
   );

   // Low-speed power-of-two stage

   // Running code above the largest power; also shown in the status byte
   assign ls_sat     = (ls_run_ff > `LS_EXP_MAX);
   // Codes past five saturate at divide by 32
   assign ls_exp_eff = ls_sat ? `LS_EXP_MAX : ls_run_ff;
   // Last period index and half point, both from the exponent
   assign ls_last = (5'h01 << ls_exp_eff) - 5'h01;
   assign ls_half = (ls_exp_eff == 3'h0) ? 5'h00 : (5'h01 << (ls_exp_eff - 3'h1));

   // Counts high-speed periods; the exponent is only swapped when a
   // low-speed period ends, so no shortened pulse reaches the output
   always @* begin
      nxt_ls_cnt = ls_cnt_ff;
      nxt_ls_run = ls_run_ff;
      if (hs_start) begin
         if (ls_cnt_ff >= ls_last) begin
            nxt_ls_cnt = 5'h00;
            nxt_ls_run = ls_active_ff;
         end else begin
            nxt_ls_cnt = ls_cnt_ff + 5'h01;
         end
      end
   end

   // High in the first half of the low-speed period only
   always @* begin
      nxt_out_pair = hs_pair;
      if (ls_exp_eff != 3'h0) begin
         nxt_out_pair = {2{(nxt_ls_cnt < ls_half)}};
      end
   end

   // Output frequency is VCO over the product of both ratios
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ls_cnt_ff        <= 5'h00;
         ls_run_ff        <= `LS_RESET;
         clk_out_pair_out <= 2'b00;
      end else begin
         ls_cnt_ff        <= nxt_ls_cnt;
         ls_run_ff        <= nxt_ls_run;
         clk_out_pair_out <= nxt_out_pair;
      end
   end
endmodule

// ===== pkg/divider_chain_defines.vh
// Constants shared by the divider chain design files
`ifndef DIVIDER_CHAIN_DEFINES_VH
`define DIVIDER_CHAIN_DEFINES_VH

// Register byte addresses
`define REG_HS_LOW        8'h17
`define REG_PACKED        8'h18
`define REG_FB_B0         8'h1a
`define REG_FB_B1         8'h1b
`define REG_FB_B2         8'h1c
`define REG_FB_B3         8'h1d
`define REG_FB_B4         8'h1e
`define REG_FB_B5         8'h1f
`define REG_CTRL          8'h87
`define REG_STATUS        8'h88

// Packed byte field positions and control apply bit
`define PACK_LS_MSB       6
`define PACK_LS_LSB       4
`define PACK_HS_MSB       2
`define PACK_HS_LSB       0
`define CTRL_APPLY_BIT    6

// Status byte bit positions
`define ST_HS_BAD         0
`define ST_FB_BAD         1
`define ST_REFUSED        2
`define ST_LS_SAT         3
`define ST_APPLIED        4

// Divider limits
`define HS_MIN            11'h005
`define HS_MAX            11'h7fe
`define HS_ODD_MAX        11'h021
`define LS_EXP_MAX        3'h5
`define FB_MIN            43'h03c_0000_0000
`define FB_MAX            43'h7fd_ffff_ffff
`define FB_FRAC_W         32
`define FB_INT_W          11

// Reset settings
`define HS_RESET          11'h046
`define LS_RESET          3'h0
`define FB_RESET          43'h047_e756_e62a

`endif

// ===== rtl/hs_divider.v
// Integer high-speed divider with half-cycle resolution output
`timescale 1ns/100ps
`include "divider_chain_defines.vh"
module hs_divider (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire [10:0] ratio_in,
   output reg  [1:0]  level_pair_out,
   output reg         period_start_out
);
   reg  [10:0] ratio_ff;
   reg  [11:0] half_ff;
   wire [11:0] span;
   wire [12:0] half_step;
   wire        wrap;
   wire [1:0]  nxt_level;

   // Two half-cycles per clock; a period is 2*ratio halves
   assign span      = {ratio_ff, 1'b0};
   assign half_step = {1'b0, half_ff} + 13'h0002;
   assign wrap      = (half_step >= {1'b0, span});

   // Ratio is only taken at a period boundary to avoid runt pulses
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ratio_ff <= `HS_RESET;
         half_ff  <= 12'h000;
      end else begin
         if (wrap) begin
            ratio_ff <= ratio_in;
            half_ff  <= 12'h000;
         end else begin
            half_ff  <= half_step[11:0];
         end
      end
   end

   // High for exactly ratio halves: 50% for odd and even ratios alike
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_half
         wire [12:0] idx;
         assign idx          = {1'b0, half_ff} + {12'h000, (g == 1)};
         assign nxt_level[g] = (idx < {2'b00, ratio_ff});
      end
   endgenerate

   // One register for both halves keeps a single driver on the pair
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         level_pair_out <= 2'b00;
      end else begin
         level_pair_out <= nxt_level;
      end
   end

   // Marks the pair that opens a new period
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         period_start_out <= 1'b0;
      end else begin
         period_start_out <= (half_ff == 12'h000);
      end
   end
endmodule

// ===== rtl/fb_divider.v
// Fractional feedback divider in 11.32 fixed point
`timescale 1ns/100ps
`include "divider_chain_defines.vh"
module fb_divider (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire [42:0] value_in,
   output reg         ref_pulse_out
);
   reg  [31:0] acc_ff;
   reg  [11:0] cnt_ff;
   wire [32:0] acc_sum;
   wire [11:0] period_len;

   // Carry out of the fraction stretches one period by a cycle
   assign acc_sum    = {1'b0, acc_ff} + {1'b0, value_in[`FB_FRAC_W-1:0]};
   assign period_len = {1'b0, value_in[42:`FB_FRAC_W]} + {11'h000, acc_sum[32]};

   // Average period equals the full fixed-point value
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         acc_ff        <= 32'h0000_0000;
         cnt_ff        <= 12'h000;
         ref_pulse_out <= 1'b0;
      end else begin
         if (cnt_ff == 12'h000) begin
            acc_ff        <= acc_sum[31:0];
            cnt_ff        <= period_len - 12'h001;
            ref_pulse_out <= 1'b1;
         end else begin
            cnt_ff        <= cnt_ff - 12'h001;
            ref_pulse_out <= 1'b0;
         end
      end
   end
endmodule

// ===== sim/divider_chain_checker.sv
// Port-level assertions for the divider chain
`timescale 1ns/100ps
module divider_chain_checker (
   input wire logic       clk_sys_in,
   input wire logic       rst_n_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       reg_rvalid_out,
   input wire logic [1:0] clk_out_pair_out,
   input wire logic       fb_ref_pulse_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   // Register bus answers exactly one cycle after each read
   read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read strobe not answered");
   no_stray_valid_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
      else $error("read valid without read");
   rdata_hold_a: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
      else $error("read data moved without read");
   packed_unused_a: assert property (
      reg_rd_in && reg_addr_in == 8'h18 |=> !reg_rdata_out[7] && !reg_rdata_out[3])
      else $error("unused packed bits not zero");
   // Control and unmapped places always read empty
   empty_reads_a: assert property (reg_rd_in && (reg_addr_in == 8'h87
      || reg_addr_in == 8'h19 || reg_addr_in == 8'h00) |=> reg_rdata_out == 8'h00)
      else $error("empty place read nonzero");
   status_spare_a: assert property (
      reg_rd_in && reg_addr_in == 8'h88 |=> reg_rdata_out[7:5] == 3'h0)
      else $error("status spare bits set");
   // Feedback value is at least 60, so pulses are far apart
   fb_spacing_a: assert property (fb_ref_pulse_out |=> !fb_ref_pulse_out [*8])
      else $error("feedback pulses too close");
   // Mid-cycle fall must be followed by a full low cycle
   mid_fall_a: assert property (clk_out_pair_out == 2'b01 |=> clk_out_pair_out == 2'b00)
      else $error("odd ratio low phase too short");
   high_hold_a: assert property (
      $rose(clk_out_pair_out[0]) && clk_out_pair_out[1] |=> clk_out_pair_out == 2'b11)
      else $error("high phase too short");
endmodule

// ===== sim/divider_host.sv
// Register host model that stages and applies divider settings
`timescale 1ns/100ps
module divider_host (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       rvalid_in,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end

   // Values pass as given; callers also write illegal ratio and feedback values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
      addr_out <= ~a; // Released lines never keep the last value
      wdata_out <= ~d;
   endtask

   // Answer lands one cycle after the strobe is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk_sys_in);
      rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_sys_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
      @(negedge clk_sys_in);
      ok = rvalid_in;
      d = rdata_in;
   endtask
endmodule

// ===== sim/programmable_divider_chain_tb_top.sv
// Self-checking bench for the divider chain
`timescale 1ns/100ps
module programmable_divider_chain_tb_top;
   logic       clk_sys_in;
   logic       rst_n_in;
   wire        reg_wr_in;
   wire        reg_rd_in;
   wire  [7:0] reg_addr_in;
   wire  [7:0] reg_wdata_in;
   wire  [7:0] reg_rdata_out;
   wire        reg_rvalid_out;
   wire  [1:0] clk_out_pair_out;
   wire        fb_ref_pulse_out;
   wire        cfg_error_out;
   int         err_count = 0;
   int         n_compared = 0;

   programmable_divider_chain dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .reg_rvalid_out(reg_rvalid_out), .clk_out_pair_out(clk_out_pair_out),
      .fb_ref_pulse_out(fb_ref_pulse_out), .cfg_error_out(cfg_error_out));
   divider_host host_u (.clk_sys_in(clk_sys_in), .rdata_in(reg_rdata_out),
      .rvalid_in(reg_rvalid_out), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
      .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));

   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      logic ok;
      host_u.rd(a, d, ok);
      chk("read valid", 32'h1, {31'h0, ok});
      chk(nm, {24'h0, e}, {24'h0, d});
   endtask

   // Stage both ratios, then apply them together
   task automatic set_div(input logic [10:0] hs, input logic [2:0] k);
      host_u.wr(8'h17, hs[7:0]);
      host_u.wr(8'h18, {1'b0, k, 1'b0, hs[10:8]});
      host_u.wr(8'h87, 8'h40);
   endtask

   task automatic set_fb(input logic [42:0] v);
      logic [47:0] x;
      x = {5'h0, v};
      for (int i = 0; i < 6; i++) host_u.wr(8'h1a + i[7:0], x[8*i +: 8]);
      host_u.wr(8'h87, 8'h40);
   endtask

   // Measures in half cycles; first rises skipped while old settings drain
   task automatic meas(input string nm, input int per, input int hi);
      int idx, rises, r0, f0;
      logic prv;
      idx = 0; rises = 0; r0 = 0; f0 = 0; prv = 1'b1;
      while (rises < 5 && idx < 40000) begin
         @(negedge clk_sys_in);
         for (int b = 0; b < 2; b++) begin
            if (clk_out_pair_out[b] && !prv) begin
               rises++;
               if (rises == 4) r0 = idx;
               if (rises == 5) chk({nm, " period"}, per, idx - r0);
            end
            if (!clk_out_pair_out[b] && prv && rises == 4) f0 = idx;
            prv = clk_out_pair_out[b];
            idx++;
         end
      end
      chk({nm, " high"}, hi, f0 - r0);
      chk({nm, " edges"}, 5, rises);
   endtask

   // Sum of two consecutive feedback intervals
   task automatic meas_fb(input int e);
      int n, c;
      n = 0; c = 0;
      while (n < 4 && c < 10000) begin
         @(negedge clk_sys_in);
         c++;
         if (fb_ref_pulse_out) begin
            n++;
            if (n == 2) c = 0;
         end
      end
      chk("fb spacing", e, c);
   endtask

   task automatic t_reset;
      rdc(8'h17, 8'h46, "hs low");
      rdc(8'h18, 8'h00, "packed");
      rdc(8'h1a, 8'h2a, "fb byte0");
      rdc(8'h1e, 8'h47, "fb byte4");
      rdc(8'h87, 8'h00, "control");
      rdc(8'h19, 8'h00, "unmapped");
      rdc(8'h00, 8'h00, "unmapped low");
      meas("reset out", 140, 70);
   endtask

   task automatic t_hs;
      int h;
      for (int i = 0; i < 4; i++) begin
         h = (i == 0) ? 5 : (i == 1) ? 33 : (i == 2) ? 34 : 2046;
         set_div(h[10:0], 3'h0);
         meas("hs ratio", 2 * h, h);
      end
   endtask

   task automatic t_ls;
      logic [7:0] s;
      logic ok;
      int r;
      for (int k = 0; k < 8; k++) begin
         r = 1 << ((k > 5) ? 5 : k);
         set_div(11'h006, k[2:0]);
         meas("ls ratio", 12 * r, 6 * r);
         host_u.rd(8'h88, s, ok);
         chk("ls saturate flag", {31'h0, k > 5}, {31'h0, s[3]});
      end
   endtask

   // Illegal ratios are refused and the output keeps running
   task automatic t_bad;
      logic [7:0] s;
      logic ok;
      int h;
      set_div(11'h006, 3'h0);
      for (int i = 0; i < 3; i++) begin
         h = (i == 0) ? 4 : (i == 1) ? 35 : 2047;
         set_div(h[10:0], 3'h0);
         repeat (2) @(negedge clk_sys_in);
         chk("cfg error", 32'h1, {31'h0, cfg_error_out});
         host_u.rd(8'h88, s, ok);
         chk("refused status", 32'h5, {24'h0, s & 8'h05});
         meas("kept out", 12, 6);
      end
      host_u.wr(8'h88, 8'h14);
      set_div(11'h006, 3'h0);
      repeat (2) @(negedge clk_sys_in);
      chk("cfg error clear", 32'h0, {31'h0, cfg_error_out});
      host_u.rd(8'h88, s, ok);
      chk("apply status", 32'h10, {24'h0, s & 8'h14});
   endtask

   task automatic t_fb;
      logic [7:0] s;
      logic ok;
      host_u.wr(8'h18, 8'h88);
      rdc(8'h18, 8'h00, "packed unused");
      host_u.wr(8'h1f, 8'hff);
      rdc(8'h1f, 8'h07, "fb top");
      set_fb(43'h03c_8000_0000);
      meas_fb(121);
      set_fb(43'h03b_ffff_ffff);
      host_u.rd(8'h88, s, ok);
      chk("fb refused", 32'h6, {24'h0, s & 8'h06});
      meas_fb(121);
      host_u.wr(8'h88, 8'h14);
      set_fb(43'h03c_0000_0000);
      meas_fb(120);
   endtask

   task automatic complete_run;
      $display("Compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      rst_n_in = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_hs();
      t_ls();
      t_bad();
      t_fb();
      complete_run();
   end

   // Run takes about 16000 cycles; 40000 cycles means a hang
   initial begin
      #160000;
      err_count++;
      complete_run();
   end
endmodule

bind programmable_divider_chain divider_chain_checker chk_u (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
   .clk_out_pair_out(clk_out_pair_out), .fb_ref_pulse_out(fb_ref_pulse_out));
